// ==== cftc_pkg.sv ====
/*
  Shared constants for the central FIFO threshold control block:
  register offsets, field positions, widths and reset values.
  Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
*/
package cftc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  TX_REFILL_OFS = 8'h48;
  localparam logic [7:0]  RX_DRAIN_OFS  = 8'h4C;
  localparam logic [31:0] TX_REFILL_RST = 32'h00000000;
  localparam logic [31:0] RX_DRAIN_RST  = 32'h00000000;

  // ----------------------------------------------------------------
  // tx refill control fields
  // ----------------------------------------------------------------
  localparam int CHANNELS  = 4;
  localparam int TX_THR_W  = 5;
  localparam int TX_LVL_W  = 7;
  localparam int TX_THR_LSB [CHANNELS] = '{27, 22, 17, 11};
  localparam int TX_M4_BIT  [CHANNELS] = '{7, 5, 3, 1};
  localparam int TX_M2_BIT  [CHANNELS] = '{6, 4, 2, 0};

  // ----------------------------------------------------------------
  // rx drain control fields
  // ----------------------------------------------------------------
  localparam int RX_THR_W   = 7;
  localparam int RX_THR_LSB = 0;
  localparam int RX_M4_BIT  = 8;
  localparam int RX_M2_BIT  = 7;
  localparam int RX_LVL_W   = 9;

  // ----------------------------------------------------------------
  // data path buffer
  // ----------------------------------------------------------------
  localparam int DATA_W     = 32;
  localparam int BUF_DEPTH  = 4;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h1,
    RX_DRAIN = 2'h2
  } cftc_rx_state_t;

endpackage : cftc_pkg

// ==== cftc_mark.sv ====
/*
  Watermark arithmetic: threshold scaled by a 1/2/4 multiplier from
  two select bits, plus an optional offset of one.
  Assumes combinational use; the caller registers any decision.
*/
`timescale 1ns/1ps
`default_nettype none

module cftc_mark #(
  parameter int THR_W = 5,
  parameter int OUT_W = 7
) (
  // threshold and selects
  input  wire logic [THR_W-1:0] thr,
  input  wire logic             timesFour,
  input  wire logic             timesTwo,
  input  wire logic             addOne,
  // result
  output logic      [OUT_W-1:0] mark
);

  logic [OUT_W-1:0] scaled;

  always_comb
  begin
    // both selects set is undefined; it falls to times four
    if (timesFour)
      scaled = OUT_W'({thr, 2'h0});
    else if (timesTwo)
      scaled = OUT_W'({thr, 1'h0});
    else
      scaled = OUT_W'(thr);
    mark = scaled + OUT_W'(addOne);
  end

endmodule : cftc_mark

`default_nettype wire

// ==== cftc_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Ready, valid and the head word come from flip-flops; allowIn gates
  acceptance.
*/
`timescale 1ns/1ps
`default_nettype none

module cftc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             allowIn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW-1:0]    rdPtr_nxt;
  logic [PW:0]      count_r;
  logic [PW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign rdPtr_nxt = rdPtr_r + PW'(pop);

  always_comb
  begin
    count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      count_r  <= '0;
      inReady  <= 1'h0;
      outValid <= 1'h0;
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + PW'(1);
      if (pop)
        rdPtr_r <= rdPtr_r + PW'(1);
      count_r  <= count_nxt;
      inReady  <= allowIn && (count_nxt < (PW+1)'(DEPTH));
      outValid <= count_nxt != '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
    // head word registered; a word written into the new head bypasses
    if (push && wrPtr_r == rdPtr_nxt)
      outData <= inData;
    else
      outData <= mem[rdPtr_nxt];
  end

endmodule : cftc_fifo

`default_nettype wire

// ==== cftc_top.sv ====
/*
  Central FIFO threshold control: two control registers on AHB-Lite,
  refill requests for four transmit sections, drain request for the
  receive FIFO, and a 4-word buffer on the drained data path.
  Assumes section and receive occupancies come from logic on clk,
  and the DMA side consumes data with valid/ready.
*/
// Implementation choice: the AHB-Lite slave port.
//
// Summary of operation
// - five-bit refill threshold per channel at bits 31:27, 26:22, 21:17, 15:11.
// - per channel times-four select at bits 7,5,3,1; times-two at 6,4,2,0.
// - refill watermark is threshold times multiplier plus one; request below it.
// - refill watermark only steers fetching from host memory, not serial side.
// - seven-bit receive threshold at bits 6:0, counted in words.
// - receive watermark is threshold times multiplier; selects at bits 8 and 7.
// - drain when receive level exceeds watermark, continue until it is empty.
// - both control registers read and write, reset to zero.
`timescale 1ns/1ps
`default_nettype none

module cftc_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [7:0]                    haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // transmit sections
  input  wire logic [cftc_pkg::CHANNELS-1:0]
                    [cftc_pkg::TX_LVL_W-1:0] txLevel,
  output logic      [cftc_pkg::CHANNELS-1:0] txRefillReq,
  // receive fifo side
  input  wire logic [cftc_pkg::RX_LVL_W-1:0] rxLevel,
  output logic                               rxDrainReq,
  input  wire logic                          rxInValid,
  output logic                               rxInReady,
  input  wire logic [cftc_pkg::DATA_W-1:0]   rxInData,
  // dma side
  output logic                               dmaValid,
  input  wire logic                          dmaReady,
  output logic      [cftc_pkg::DATA_W-1:0]   dmaData
);

  import cftc_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstnSync;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_r <= 1'h0;
      rstnSync  <= 1'h0;
    end
    else
    begin
      rstMeta_r <= 1'h1;
      rstnSync  <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        [31:0] txCtrl_r;
  logic        [31:0] rxCtrl_r;
  logic               addrPhase;
  logic               wrPend_r;
  logic        [7:0]  wrAddr_r;
  logic        [31:0] txView;
  logic        [31:0] rxView;

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

  // pending write seen by a read issued in its data phase
  always_comb
  begin
    txView = txCtrl_r;
    rxView = rxCtrl_r;
    if (wrPend_r && wrAddr_r == TX_REFILL_OFS)
      txView = hwdata;
    if (wrPend_r && wrAddr_r == RX_DRAIN_OFS)
      rxView = hwdata;
  end

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      wrPend_r <= 1'h0;
      wrAddr_r <= 8'h00;
    end
    else
    begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr;
    end
  end

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      txCtrl_r <= TX_REFILL_RST;
      rxCtrl_r <= RX_DRAIN_RST;
    end
    else if (wrPend_r)
    begin
      if (wrAddr_r == TX_REFILL_OFS)
        txCtrl_r <= hwdata;
      if (wrAddr_r == RX_DRAIN_OFS)
        rxCtrl_r <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
      hrdata <= 32'h00000000;
    else if (addrPhase && !hwrite)
    begin
      case (haddr)
        TX_REFILL_OFS: hrdata <= txView;
        RX_DRAIN_OFS:  hrdata <= rxView;
        default:       hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // transmit refill watermarks
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0][TX_LVL_W-1:0] txMark;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : gTx
      cftc_mark #(
        .THR_W (TX_THR_W),
        .OUT_W (TX_LVL_W)
      ) uMark (
        .thr       (txCtrl_r[TX_THR_LSB[gi] +: TX_THR_W]),
        .timesFour (txCtrl_r[TX_M4_BIT[gi]]),
        .timesTwo  (txCtrl_r[TX_M2_BIT[gi]]),
        .addOne    (1'h1),
        .mark      (txMark[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
      txRefillReq <= '0;
    else
      for (int i = 0; i < CHANNELS; i++)
        txRefillReq[i] <= txLevel[i] < txMark[i];
  end

  // ----------------------------------------------------------------
  // receive drain control
  // ----------------------------------------------------------------
  logic [RX_LVL_W-1:0] rxMark;
  cftc_rx_state_t      rxState_r;
  cftc_rx_state_t      rxState_nxt;

  cftc_mark #(
    .THR_W (RX_THR_W),
    .OUT_W (RX_LVL_W)
  ) uRxMark (
    .thr       (rxCtrl_r[RX_THR_LSB +: RX_THR_W]),
    .timesFour (rxCtrl_r[RX_M4_BIT]),
    .timesTwo  (rxCtrl_r[RX_M2_BIT]),
    .addOne    (1'h0),
    .mark      (rxMark)
  );

  // start above mark, run to empty
  always_comb
  begin
    case (rxState_r)
      RX_IDLE:
        rxState_nxt = (rxLevel > rxMark) ? RX_DRAIN : RX_IDLE;
      RX_DRAIN:
        rxState_nxt = (rxLevel == '0) ? RX_IDLE : RX_DRAIN;
      default:
        rxState_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      rxState_r  <= RX_IDLE;
      rxDrainReq <= 1'h0;
    end
    else
    begin
      rxState_r  <= rxState_nxt;
      rxDrainReq <= rxState_nxt == RX_DRAIN;
    end
  end

  // ----------------------------------------------------------------
  // drained data buffer
  // ----------------------------------------------------------------
  cftc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) uBuf (
    .clk      (clk),
    .rstn     (rstnSync),
    .allowIn  (rxState_nxt == RX_DRAIN),
    .inValid  (rxInValid),
    .inReady  (rxInReady),
    .inData   (rxInData),
    .outValid (dmaValid),
    .outReady (dmaReady),
    .outData  (dmaData)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstnSync);

  logic [2:0] txMul0;
  logic [3:0] rxMul;
  assign txMul0 = txCtrl_r[7] ? 3'h4 : (txCtrl_r[6] ? 3'h2 : 3'h1);
  assign rxMul  = rxCtrl_r[8] ? 4'h4 : (rxCtrl_r[7] ? 4'h2 : 4'h1);

  property p_reset_zero;
    @(posedge clk) $rose(rstnSync) |-> txCtrl_r == 32'h00000000
      && rxCtrl_r == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control registers not zero after reset");

  property p_write_tx;
    addrPhase && hwrite && haddr == TX_REFILL_OFS
      |-> ##2 txCtrl_r == $past(hwdata);
  endproperty
  a_write_tx: assert property (p_write_tx)
    else $error("tx refill control write lost");

  property p_read_rx;
    addrPhase && !hwrite && haddr == RX_DRAIN_OFS && !wrPend_r
      |=> hrdata == $past(rxCtrl_r);
  endproperty
  a_read_rx: assert property (p_read_rx)
    else $error("rx drain control read wrong");

  property p_tx_mark0;
    !(txCtrl_r[7] && txCtrl_r[6]) |->
      txMark[0] == 7'(txCtrl_r[31:27] * txMul0 + 7'h01);
  endproperty
  a_tx_mark0: assert property (p_tx_mark0)
    else $error("channel 0 refill watermark wrong");

  property p_tx_req3;
    txLevel[3] < 7'(txCtrl_r[15:11] * (txCtrl_r[1] ? 3'h4
      : (txCtrl_r[0] ? 3'h2 : 3'h1)) + 7'h01) |=> txRefillReq[3];
  endproperty
  a_tx_req3: assert property (p_tx_req3)
    else $error("channel 3 refill request missing");

  property p_tx_quiet2;
    txLevel[2] >= 7'(txCtrl_r[21:17] * (txCtrl_r[3] ? 3'h4
      : (txCtrl_r[2] ? 3'h2 : 3'h1)) + 7'h01) |=> !txRefillReq[2];
  endproperty
  a_tx_quiet2: assert property (p_tx_quiet2)
    else $error("channel 2 refill asked above watermark");

  property p_rx_mark;
    !(rxCtrl_r[8] && rxCtrl_r[7]) |->
      rxMark == 9'(rxCtrl_r[6:0] * rxMul);
  endproperty
  a_rx_mark: assert property (p_rx_mark)
    else $error("receive watermark wrong");

  property p_rx_start;
    !rxDrainReq && rxLevel > rxMark |=> rxDrainReq;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("drain not started above watermark");

  property p_rx_hold;
    rxDrainReq && rxLevel != '0 |=> rxDrainReq;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("drain stopped before receive fifo empty");

  property p_rx_stop;
    rxDrainReq && rxLevel == '0 |=> !rxDrainReq && !rxInReady;
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("drain or intake kept after receive fifo empty");

  // buffer occupancy seen from both handshakes
  logic [2:0] bufCnt_r;

  always_ff @(posedge clk or negedge rstnSync)
  begin
    if (!rstnSync)
      bufCnt_r <= 3'h0;
    else
      bufCnt_r <= bufCnt_r + 3'(rxInValid && rxInReady)
        - 3'(dmaValid && dmaReady);
  end

  property p_buf_stall;
    bufCnt_r == 3'(BUF_DEPTH) |-> !rxInReady;
  endproperty
  a_buf_stall: assert property (p_buf_stall)
    else $error("buffer accepts while full");

endmodule : cftc_top

`default_nettype wire

// ==== cftc_dma_model.sv ====
/*
  DMA-side sink for the drained receive words.
  Assumes the bench steers stalling through hold and slow.
*/
`timescale 1ns/1ps
`default_nettype none

module cftc_dma_model (
  // clock and control
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic hold,
  input  wire logic slow,
  // buffered word handshake
  output logic      dmaReady
);
  logic phase_r;

  // far side takes words promptly or every other cycle, and none while hold is set
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r  <= 1'b0;
      dmaReady <= 1'b0;
    end
    else
    begin
      phase_r  <= ~phase_r;
      dmaReady <= !hold && (!slow || phase_r);
    end
  end
endmodule : cftc_dma_model

`default_nettype wire

// ==== test_cftc_top.sv ====
/*
  Self-checking bench for the threshold control block.
  Assumes zero-wait AHB-Lite slave and the DMA sink model.
*/
`timescale 1ns/1ps
`default_nettype none

module test_cftc_top;
  import cftc_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                                 clk, rstn, hsel, hwrite;
  logic [7:0]                           haddr;
  logic [1:0]                           htrans;
  logic [2:0]                           hsize;
  logic [31:0]                          hwdata, hrdata, rd, cfg;
  logic                                 hreadyout, hresp, rxDrainReq;
  logic [CHANNELS-1:0][TX_LVL_W-1:0]    txLevel;
  logic [CHANNELS-1:0]                  txRefillReq;
  logic [RX_LVL_W-1:0]                  rxLevel;
  logic                                 rxInValid, rxInReady, hold, slow;
  logic                                 dmaValid, dmaReady;
  logic [DATA_W-1:0]                    rxInData, dmaData;
  logic [DATA_W-1:0]                    q [$];
  int                                   error_cnt, num_checks, seed;
  int                                   m, r, i, mark, k;
  int                                   mk [CHANNELS];
  int                                   off [CHANNELS];
  logic [3:0]                           expReq;

  cftc_top dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .txLevel(txLevel), .txRefillReq(txRefillReq),
    .rxLevel(rxLevel), .rxDrainReq(rxDrainReq), .rxInValid(rxInValid),
    .rxInReady(rxInReady), .rxInData(rxInData), .dmaValid(dmaValid),
    .dmaReady(dmaReady), .dmaData(dmaData));

  cftc_dma_model sink (.clk(clk), .rstn(rstn), .hold(hold), .slow(slow),
    .dmaReady(dmaReady));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task automatic push(input int n);
    int c;
    repeat (n)
    begin
      rxInValid <= 1'b1;
      rxInData  <= $random(seed);
      c = 0;
      do
      begin
        @(posedge clk);
        c++;
      end
      while (rxInReady !== 1'b1 && c < 60);
      if (c >= 60)
      begin
        error_cnt++;
        print_verdict();
      end
      q.push_back(rxInData);
    end
    rxInValid <= 1'b0;
  endtask : push

  // ----------------------------------------------------------------
  // drained word watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (dmaValid === 1'b1 && dmaReady === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(dmaData, q.pop_front());
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 98;
    error_cnt = 0;
    num_checks = 0;
    {rstn, hwrite, haddr, htrans, hwdata} = '0;
    {txLevel, rxLevel, rxInValid, rxInData, slow} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    hold = 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(txRefillReq), 32'hF);
    ahb(1'b0, TX_REFILL_OFS, 32'h0);
    check(rd, TX_REFILL_RST);
    ahb(1'b0, RX_DRAIN_OFS, 32'h0);
    check(rd, RX_DRAIN_RST);
    ahb(1'b0, 8'h50, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'(HRESP_OKAY));
    check(32'(hreadyout), 32'h1);
    for (m = 0; m < 3; m++)
    begin
      cfg = $random(seed) & 32'hFFFEF800;
      for (i = 0; i < CHANNELS; i++)
      begin
        if (m == 1) cfg[TX_M2_BIT[i]] = 1'b1;
        if (m == 2) cfg[TX_M4_BIT[i]] = 1'b1;
        mk[i] = int'(cfg[TX_THR_LSB[i] +: TX_THR_W]) * (1 << m) + 1;
      end
      ahb(1'b1, TX_REFILL_OFS, cfg);
      ahb(1'b0, TX_REFILL_OFS, 32'h0);
      check(rd & 32'hFFFEF8FF, cfg);
      for (r = 0; r < 3; r++)
      begin
        for (i = 0; i < CHANNELS; i++)
        begin
          off[i] = ($random(seed) & 1) - 1;
          expReq[i] = off[i] < 0;
          txLevel[i] <= 7'(mk[i] + off[i]);
        end
        repeat (3) @(posedge clk);
        check(32'(txRefillReq), 32'(expReq));
      end
      k = ($random(seed) & 32'h7F) | 1;
      mark = k << m;
      cfg = 32'(k) | (m == 1 ? 32'h80 : 32'h0) | (m == 2 ? 32'h100 : 32'h0);
      ahb(1'b1, RX_DRAIN_OFS, cfg);
      ahb(1'b0, RX_DRAIN_OFS, 32'h0);
      check(rd & 32'h1FF, cfg);
      rxLevel <= 9'(mark);
      repeat (3) @(posedge clk);
      check(32'(rxDrainReq), 32'h0);
      rxLevel <= 9'(mark + 1);
      repeat (3) @(posedge clk);
      check(32'(rxDrainReq), 32'h1);
      rxLevel <= 9'h001;
      hold <= 1'b1;
      push(BUF_DEPTH);
      repeat (2) @(posedge clk);
      check(32'(rxInReady), 32'h0);
      check(32'(rxDrainReq), 32'h1);
      hold <= 1'b0;
      slow <= m[0];
      push(3);
      rxLevel <= 9'h000;
      repeat (3) @(posedge clk);
      check(32'(rxDrainReq), 32'h0);
      check(32'(rxInReady), 32'h0);
      k = 0;
      while (q.size() != 0 && k < 100)
      begin
        @(posedge clk);
        k++;
      end
      check(32'(q.size()), 32'h0);
    end
    print_verdict();
  end
endmodule : test_cftc_top

`default_nettype wire
